// ### hdl/avcm_consts.vh
// Constant definitions for the analog value code mapper
`ifndef AVCM_CONSTS_VH
`define AVCM_CONSTS_VH

// Special result codes
`define AVCM_CODE_OVF 16'h7fff
`define AVCM_CODE_UDF 16'h8000
`define AVCM_CODE_ZERO 16'h0000
// Top of overdrive range, 32511
`define AVCM_CODE_ODR 16'h7eff
// Sign bit position
`define AVCM_SIGN_BIT 15
// Lowest used output bit, 12 bit plus sign
`define AVCM_OUT_LSB 3

// Linear scale: raw full scale 4096 -> 27648 = raw * 27 / 4
`define AVCM_VSCALE_MUL 6'h1b
`define AVCM_VSCALE_SHR 2

// Thermometer limits in 0.01 degree, 18 bit two's complement
`define AVCM_T_C_HI 18'h03c8c
`define AVCM_T_C_LO 18'h3c75c
`define AVCM_T_F_HI 18'h0797c
`define AVCM_T_F_LO 18'h3a68c

// Mode byte fields
`define AVCM_TYPE_MSB 7
`define AVCM_TYPE_LSB 4
`define AVCM_RANGE_MSB 3
`define AVCM_RANGE_LSB 0

// Measuring and output types
`define AVCM_TYPE_OFF 4'h0
`define AVCM_TYPE_VOLT 4'h1
`define AVCM_TYPE_RES 4'h4
`define AVCM_TYPE_RTD 4'h8

// Ranges
`define AVCM_RNG_OFF 4'h0
`define AVCM_RNG_10V 4'h8
`define AVCM_RNG_10K 4'h9
`define AVCM_RNG_PT 4'h0

// Power-on modes
`define AVCM_IN_MODE_RST 8'h80
`define AVCM_OUT_MODE_RST 8'h18

// Timing
`define AVCM_CLK_NS 50
`define AVCM_TMO_NS 1000000

`endif

// ### hdl/avcm_in_map.v
// Input result to signed 16-bit word mapping for one channel
`timescale 1ns/1ps
`include "avcm_consts.vh"
module avcm_in_map #(
  parameter RAW_W = 18
) (
  input wire [7:0] mode,
  input wire signed [RAW_W-1:0] raw,
  input wire fahr,
  input wire analog_on,
  output reg [15:0] word
);
  localparam signed [RAW_W+5:0] LIM_ODR = {{(RAW_W-10){1'b0}}, `AVCM_CODE_ODR};
  localparam signed [RAW_W-1:0] T_C_HI = `AVCM_T_C_HI;
  localparam signed [RAW_W-1:0] T_C_LO = `AVCM_T_C_LO;
  localparam signed [RAW_W-1:0] T_F_HI = `AVCM_T_F_HI;
  localparam signed [RAW_W-1:0] T_F_LO = `AVCM_T_F_LO;

  wire [3:0] ty = mode[`AVCM_TYPE_MSB:`AVCM_TYPE_LSB];
  wire [3:0] rg = mode[`AVCM_RANGE_MSB:`AVCM_RANGE_LSB];
  wire signed [RAW_W+5:0] prod = raw * $signed(`AVCM_VSCALE_MUL);
  wire signed [RAW_W+5:0] scaled = prod >>> `AVCM_VSCALE_SHR;
  wire signed [RAW_W-1:0] t_hi = fahr ? T_F_HI : T_C_HI;
  wire signed [RAW_W-1:0] t_lo = fahr ? T_F_LO : T_C_LO;
  wire lin_ok = (ty == `AVCM_TYPE_VOLT && rg == `AVCM_RNG_10V) ||
                (ty == `AVCM_TYPE_RES && rg == `AVCM_RNG_10K);
  wire rtd_ok = (ty == `AVCM_TYPE_RTD && rg == `AVCM_RNG_PT);

  always @* begin
    word = `AVCM_CODE_OVF;
    if (!analog_on || !(lin_ok || rtd_ok)) begin
      word = `AVCM_CODE_OVF;
    end else if (lin_ok) begin
      if (scaled[RAW_W+5])
        word = `AVCM_CODE_ZERO;
      else if (scaled > LIM_ODR)
        word = `AVCM_CODE_OVF;
      else
        word = scaled[15:0];
    end else begin
      // Temperature already linearised in the selected unit
      if (raw > t_hi)
        word = `AVCM_CODE_OVF;
      else if (raw < t_lo)
        word = `AVCM_CODE_UDF;
      else
        word = raw[15:0];
    end
  end
endmodule

// ### hdl/avcm_out_map.v
// Output word to converter code mapping for one channel
`timescale 1ns/1ps
`include "avcm_consts.vh"
module avcm_out_map #(
  parameter DAC_W = 12
) (
  input wire [7:0] mode,
  input wire [15:0] word,
  output reg [DAC_W-1:0] code
);
  wire [3:0] ty = mode[`AVCM_TYPE_MSB:`AVCM_TYPE_LSB];
  wire [3:0] rg = mode[`AVCM_RANGE_MSB:`AVCM_RANGE_LSB];
  wire ok = (ty == `AVCM_TYPE_VOLT && rg == `AVCM_RNG_10V);

  always @* begin
    code = {DAC_W{1'b0}};
    // Sign set covers underdrive and underflow alike
    if (!ok || word[`AVCM_SIGN_BIT] || word > `AVCM_CODE_ODR)
      code = {DAC_W{1'b0}};
    else
      code = word[`AVCM_SIGN_BIT-1 -: DAC_W];
  end
endmodule

// ### hdl/avcm_top.v
// Analog value code mapper: channel scheduling, modes and result words
`timescale 1ns/1ps
`include "avcm_consts.vh"
module avcm_top #(
  parameter RAW_W = 18,
  parameter DAC_W = 12,
  parameter TMO_CYC = `AVCM_TMO_NS / `AVCM_CLK_NS
) (
  input wire ref_clk,
  input wire sys_rst,
  input wire cfg_load,
  input wire [31:0] cfg_in_mode,
  input wire [15:0] cfg_out_mode,
  input wire temp_fahr,
  input wire analog_on,
  input wire [31:0] out_words,
  input wire adc_done,
  input wire signed [RAW_W-1:0] adc_raw,
  output reg adc_req_q,
  output reg [1:0] adc_chan_q,
  output reg [63:0] in_words_q,
  output reg [4*1-1:0] in_fresh_q,
  output reg [2*DAC_W-1:0] dac_codes_q,
  output reg dac_load_q,
  output reg dac_chan_q,
  output reg [5:0] cfg_err_q,
  output reg conv_tmo_q,
  output reg cycle_done_q
);
  localparam N_IN = 4;
  localparam [2:0] SLOT_LAST = 3'h5;
  localparam [31:0] TMO_LIM = TMO_CYC;

  localparam [2:0] S_START = 3'h0;
  localparam [2:0] S_PICK = 3'h1;
  localparam [2:0] S_WAIT = 3'h2;
  localparam [2:0] S_STORE = 3'h3;
  localparam [2:0] S_OUT = 3'h4;
  localparam [2:0] S_END = 3'h5;

  //////////////////////////////////////////////////////////////////////
  // Channel modes

  reg [31:0] in_mode_q;
  reg [15:0] out_mode_q;
  reg fahr_q;

  always @(posedge ref_clk) begin
    if (sys_rst) begin
      in_mode_q <= {N_IN{`AVCM_IN_MODE_RST}};
      out_mode_q <= {2{`AVCM_OUT_MODE_RST}};
      fahr_q <= 1'b0;
    end else if (cfg_load) begin
      // New modes apply from the next slot; only fahr_q also changes a conversion already running
      in_mode_q <= cfg_in_mode;
      out_mode_q <= cfg_out_mode;
      fahr_q <= temp_fahr;
    end
  end

  // Mode checks, repeated for error flags
  function mode_bad;
    input [7:0] m;
    input is_out;
    reg [3:0] ty;
    reg [3:0] rg;
    begin
      ty = m[`AVCM_TYPE_MSB:`AVCM_TYPE_LSB];
      rg = m[`AVCM_RANGE_MSB:`AVCM_RANGE_LSB];
      if (ty == `AVCM_TYPE_OFF && rg == `AVCM_RNG_OFF)
        mode_bad = 1'b0;
      else if (is_out)
        mode_bad = !(ty == `AVCM_TYPE_VOLT && rg == `AVCM_RNG_10V);
      else
        mode_bad = !((ty == `AVCM_TYPE_VOLT && rg == `AVCM_RNG_10V) ||
                     (ty == `AVCM_TYPE_RES && rg == `AVCM_RNG_10K) ||
                     (ty == `AVCM_TYPE_RTD && rg == `AVCM_RNG_PT));
    end
  endfunction

  function mode_off;
    input [7:0] m;
    begin
      mode_off = (m[`AVCM_TYPE_MSB:`AVCM_TYPE_LSB] == `AVCM_TYPE_OFF);
    end
  endfunction

  //////////////////////////////////////////////////////////////////////
  // Slot scheduler

  reg [2:0] state_q;
  reg [2:0] state_d;
  reg [2:0] slot_q;
  reg [2:0] slot_d;
  reg [31:0] tmo_q;
  reg signed [RAW_W-1:0] raw_q;
  reg tmo_hit_q;
  reg [7:0] slot_mode_q;
  reg slot_skip_q;

  wire [1:0] in_idx = slot_q[1:0];
  wire out_idx = slot_q[0];
  wire is_out_slot = (slot_q >= N_IN);
  wire [7:0] cur_in_mode = in_mode_q[in_idx*8 +: 8];
  wire [7:0] cur_out_mode = out_mode_q[out_idx*8 +: 8];
  wire cur_off = is_out_slot ? mode_off(cur_out_mode)
                             : mode_off(cur_in_mode);
  wire tmo_now = (tmo_q >= TMO_LIM - 1);

  always @* begin
    state_d = state_q;
    slot_d = slot_q;
    case (state_q)
      S_START: begin
        slot_d = 3'h0;
        state_d = S_PICK;
      end
      S_PICK: begin
        // Skipped output slots cost one cycle, skipped input slots two (S_PICK, S_STORE), instead of a conversion
        if (cur_off && !is_out_slot) begin
          state_d = S_STORE;
        end else if (cur_off) begin
          state_d = (slot_q == SLOT_LAST) ? S_END : S_PICK;
          slot_d = slot_q + 3'h1;
        end else if (is_out_slot) begin
          state_d = S_OUT;
        end else if (!analog_on) begin
          state_d = S_STORE;
        end else begin
          state_d = S_WAIT;
        end
      end
      S_WAIT: begin
        if (adc_done || tmo_now)
          state_d = S_STORE;
      end
      S_STORE: begin
        state_d = S_PICK;
        slot_d = slot_q + 3'h1;
      end
      S_OUT: begin
        state_d = (slot_q == SLOT_LAST) ? S_END : S_PICK;
        slot_d = slot_q + 3'h1;
      end
      S_END: begin
        state_d = S_START;
      end
      default: begin
        state_d = S_START;
        slot_d = 3'h0;
      end
    endcase
  end

  always @(posedge ref_clk) begin
    if (sys_rst) begin
      state_q <= S_START;
      slot_q <= 3'h0;
    end else begin
      state_q <= state_d;
      slot_q <= slot_d;
    end
  end

  // Mode frozen per slot, so a reload remaps a running conversion only through fahr_q, which is not frozen
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      slot_mode_q <= 8'h0;
      slot_skip_q <= 1'b0;
    end else if (state_q == S_PICK) begin
      slot_mode_q <= is_out_slot ? cur_out_mode : cur_in_mode;
      // No conversion ran, so raw_q is stale and is never mapped
      slot_skip_q <= (state_d != S_WAIT);
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Converter handshake

  always @(posedge ref_clk) begin
    if (sys_rst) begin
      adc_req_q <= 1'b0;
      adc_chan_q <= 2'h0;
      tmo_q <= 32'h0;
      raw_q <= {RAW_W{1'b0}};
      tmo_hit_q <= 1'b0;
    end else begin
      adc_req_q <= 1'b0;
      if (state_q == S_PICK) begin
        // Cleared every slot, so a skipped channel shows no old timeout
        tmo_q <= 32'h0;
        tmo_hit_q <= 1'b0;
        if (state_d == S_WAIT) begin
          adc_req_q <= 1'b1;
          adc_chan_q <= in_idx;
        end
      end else if (state_q == S_WAIT) begin
        // Timeout keeps a dead converter from stalling the whole pass
        tmo_q <= tmo_q + 32'h1;
        if (adc_done)
          raw_q <= adc_raw;
        else if (tmo_now)
          tmo_hit_q <= 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Result mapping

  wire [15:0] map_word;
  wire [DAC_W-1:0] map_code;
  // A silent converter or disabled channel is reported as an error
  wire [7:0] map_in_mode = (slot_skip_q || tmo_hit_q) ? 8'hff : slot_mode_q;

  avcm_in_map #(
    .RAW_W(RAW_W)
  ) avcm_in_map_i (
    .mode(map_in_mode),
    .raw(raw_q),
    .fahr(fahr_q),
    .analog_on(analog_on),
    .word(map_word)
  );

  avcm_out_map #(
    .DAC_W(DAC_W)
  ) avcm_out_map_i (
    .mode(slot_mode_q),
    .word(out_words[out_idx*16 +: 16]),
    .code(map_code)
  );

  always @(posedge ref_clk) begin
    if (sys_rst) begin
      in_words_q <= {N_IN{`AVCM_CODE_OVF}};
      in_fresh_q <= 4'h0;
      dac_codes_q <= {2*DAC_W{1'b0}};
      dac_load_q <= 1'b0;
      dac_chan_q <= 1'b0;
      conv_tmo_q <= 1'b0;
      cycle_done_q <= 1'b0;
    end else begin
      dac_load_q <= 1'b0;
      cycle_done_q <= 1'b0;
      if (state_q == S_START)
        in_fresh_q <= 4'h0;
      if (state_q == S_STORE) begin
        in_words_q[in_idx*16 +: 16] <= map_word;
        in_fresh_q[in_idx] <= 1'b1;
        conv_tmo_q <= tmo_hit_q;
      end
      // A deactivated output is skipped and keeps its last code
      if (state_q == S_OUT) begin
        dac_codes_q[out_idx*DAC_W +: DAC_W] <= map_code;
        dac_load_q <= 1'b1;
        dac_chan_q <= out_idx;
      end
      // One pulse per pass marks a coherent set of words
      if (state_q == S_END)
        cycle_done_q <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Mode error flags

  integer k;
  reg [5:0] err_d;

  always @* begin
    err_d = 6'h0;
    for (k = 0; k < N_IN; k = k + 1)
      err_d[k] = mode_bad(in_mode_q[k*8 +: 8], 1'b0);
    for (k = 0; k < 2; k = k + 1)
      err_d[N_IN+k] = mode_bad(out_mode_q[k*8 +: 8], 1'b1);
  end

  always @(posedge ref_clk) begin
    if (sys_rst)
      cfg_err_q <= 6'h0;
    else
      cfg_err_q <= err_d;
  end
endmodule

// ### testbench/avcm_checker_properties.sv
// Port checks for the code mapper top
`timescale 1ns/1ps
module avcm_checker (
  input wire ref_clk,
  input wire sys_rst,
  input wire analog_on,
  input wire [31:0] out_words,
  input wire adc_done,
  input wire adc_req_q,
  input wire [1:0] adc_chan_q,
  input wire [63:0] in_words_q,
  input wire [3:0] in_fresh_q,
  input wire [23:0] dac_codes_q,
  input wire dac_load_q,
  input wire dac_chan_q,
  input wire [5:0] cfg_err_q,
  input wire cycle_done_q
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  //////////////////////////////////////////
  a_reset_words: assert property (disable iff (1'b0)
    sys_rst |=> in_words_q == {4{16'h7fff}} && dac_codes_q == 24'h0)
    else $error("reset values wrong");
  a_req_single: assert property (
    adc_req_q |=> !adc_req_q) else $error("request too long");
  a_store_delay: assert property (
    adc_done |-> ##2 in_fresh_q[adc_chan_q])
    else $error("word not stored two cycles after done");
  a_off_no_req: assert property (
    !analog_on && !$past(analog_on) |-> !adc_req_q)
    else $error("request while analog part off");
  // Judged at the store itself, as the word then stands a whole pass
  a_off_word: assert property (
    $rose(in_fresh_q[0]) && !$past(analog_on)
    |-> in_words_q[15:0] == 16'h7fff) else $error("off word not 7fff");
  a_done_pulse: assert property (
    cycle_done_q |=> !cycle_done_q) else $error("cycle end too long");
  a_dac_hold: assert property (
    dac_load_q |=> !dac_load_q && $stable(dac_codes_q))
    else $error("output code not held");
  a_dac_neg: assert property (
    dac_load_q && (dac_chan_q ? $past(out_words[31]) : $past(out_words[15]))
    |-> dac_codes_q[dac_chan_q*12 +: 12] == 12'h000)
    else $error("negative word not zero volts");
  a_dac_cap: assert property (
    dac_load_q |-> dac_codes_q[dac_chan_q*12 +: 12] <= 12'hfdf)
    else $error("output code above overdrive");
  a_dac_scale: assert property (
    dac_load_q && !dac_chan_q && !$past(cfg_err_q[4])
    && $past(out_words[15:0]) <= 16'h7eff
    |-> dac_codes_q[11:0] == $past(out_words[14:3]))
    else $error("output code bits wrong");
endmodule

// ### testbench/avcm_adc_model.sv
// Behavioural converter answering conversion requests
`timescale 1ns/1ps
module avcm_adc_model (
  input wire ref_clk,
  input wire sys_rst,
  input wire adc_req_q,
  input wire [1:0] adc_chan_q,
  input wire [71:0] raw_tab,
  input wire [2:0] lag,
  input wire mute,
  output reg adc_done,
  output reg [17:0] adc_raw
);
  reg busy_q = 1'b0;
  reg [2:0] cnt_q = 3'h0;
  initial adc_done = 1'b0;
  initial adc_raw = 18'h0;
  always @(posedge ref_clk) begin
    adc_done <= 1'b0;
    // Stale data flips each cycle so nobody can rely on it
    adc_raw <= ~adc_raw;
    if (sys_rst) begin
      busy_q <= 1'b0;
    end else if (adc_req_q && !mute) begin
      busy_q <= 1'b1;
      cnt_q <= lag;
    end else if (busy_q && cnt_q == 3'h0) begin
      busy_q <= 1'b0;
      adc_done <= 1'b1;
      adc_raw <= raw_tab[adc_chan_q*18 +: 18];
    end else if (busy_q) begin
      cnt_q <= cnt_q - 3'h1;
    end
  end
endmodule

// ### testbench/analog_value_code_mapper_tb_top.sv
// Random and corner-case bench for the code mapper
`timescale 1ns/1ps
module analog_value_code_mapper_tb_top;
  localparam [7:0] INS [0:4] = '{8'h00, 8'h18, 8'h49, 8'h80, 8'h45};
  localparam [17:0] RAWS [0:9] = '{18'h01000, 18'h012d0, 18'h012d1,
    18'h3fffb, 18'h03c8c, 18'h03c8d, 18'h3c75c, 18'h3c75b, 18'h0797c,
    18'h3a68b};
  localparam [15:0] WDS [0:5] = '{16'h6c00, 16'h7eff, 16'h7f00, 16'h8000,
    16'he500, 16'h0008};
  reg ref_clk = 1'b0;
  reg sys_rst = 1'b1;
  reg cfg_load = 1'b0;
  reg [31:0] cfg_in_mode = 32'h80808080;
  reg [15:0] cfg_out_mode = 16'h1818;
  reg temp_fahr = 1'b0;
  reg analog_on = 1'b1;
  reg [31:0] out_words = 32'h0;
  reg [71:0] raw_tab = 72'h0;
  reg [2:0] lag = 3'h1;
  reg mute = 1'b0;
  reg [31:0] im;
  wire adc_done, adc_req_q, dac_load_q, dac_chan_q, conv_tmo_q, cycle_done_q;
  wire [17:0] adc_raw;
  wire [1:0] adc_chan_q;
  wire [63:0] in_words_q;
  wire [3:0] in_fresh_q;
  wire [23:0] dac_codes_q;
  wire [5:0] cfg_err_q;
  integer err_total = 0;
  integer checks = 0;
  integer i;
  integer n;
  always #25 ref_clk = ~ref_clk;
  // Short timeout keeps the muted-converter pass brief
  avcm_top #(.TMO_CYC(50)) avcm_top_i (.ref_clk(ref_clk),
    .sys_rst(sys_rst), .cfg_load(cfg_load), .cfg_in_mode(cfg_in_mode),
    .cfg_out_mode(cfg_out_mode), .temp_fahr(temp_fahr),
    .analog_on(analog_on), .out_words(out_words), .adc_done(adc_done),
    .adc_raw(adc_raw), .adc_req_q(adc_req_q), .adc_chan_q(adc_chan_q),
    .in_words_q(in_words_q), .in_fresh_q(in_fresh_q),
    .dac_codes_q(dac_codes_q), .dac_load_q(dac_load_q),
    .dac_chan_q(dac_chan_q), .cfg_err_q(cfg_err_q),
    .conv_tmo_q(conv_tmo_q), .cycle_done_q(cycle_done_q));
  avcm_adc_model avcm_adc_model_i (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .adc_req_q(adc_req_q), .adc_chan_q(adc_chan_q), .raw_tab(raw_tab),
    .lag(lag), .mute(mute), .adc_done(adc_done), .adc_raw(adc_raw));
  //////////////////////////////////////////
  task automatic check(input [63:0] seen, input [63:0] want);
    checks = checks + 1;
    if (seen !== want) begin
      err_total = err_total + 1;
      $display("wrong value at %0t: %h vs %h", $time, seen, want);
    end
  endtask
  task final_report;
    if (err_total == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  function automatic [15:0] exp_in(input integer c);
    reg [7:0] m;
    reg signed [17:0] r;
    integer s;
    begin
      m = cfg_in_mode[c*8 +: 8];
      r = raw_tab[c*18 +: 18];
      s = r * 27 / 4;
      if (!analog_on || mute || !(m inside {8'h18, 8'h49, 8'h80}))
        exp_in = 16'h7fff;
      else if (m != 8'h80)
        exp_in = s < 0 ? 16'h0 : (s > 32'sh7eff ? 16'h7fff : s[15:0]);
      else if (r > (temp_fahr ? 18'sh0797c : 18'sh03c8c))
        exp_in = 16'h7fff;
      else if (r < (temp_fahr ? 18'sh3a68c : 18'sh3c75c))
        exp_in = 16'h8000;
      else
        exp_in = r[15:0];
    end
  endfunction
  function automatic [11:0] exp_out(input integer c);
    reg [15:0] w;
    begin
      w = out_words[c*16 +: 16];
      exp_out = 12'h0;
      if (cfg_out_mode[c*8 +: 8] == 8'h18 && w <= 16'h7eff)
        exp_out = w[14:3];
    end
  endfunction
  function automatic [5:0] errs();
    integer c;
    begin
      for (c = 0; c < 4; c++)
        errs[c] = !(cfg_in_mode[c*8 +: 8] inside {8'h00, 8'h18, 8'h49, 8'h80});
      for (c = 0; c < 2; c++)
        errs[c+4] = !(cfg_out_mode[c*8 +: 8] inside {8'h00, 8'h18});
    end
  endfunction
  task automatic run(input ld, input [31:0] mi, input [15:0] mo,
    input f, input on);
    integer k;
    integer t;
    begin
      @(posedge ref_clk);
      cfg_in_mode <= mi;
      cfg_out_mode <= mo;
      temp_fahr <= f;
      analog_on <= on;
      cfg_load <= ld;
      @(posedge ref_clk);
      cfg_load <= 1'b0;
      // First pass may mix old modes, so judge the second
      k = 0;
      for (t = 0; t < 3000 && k < 2; t++) begin
        @(posedge ref_clk);
        if (cycle_done_q === 1'b1) k++;
      end
      check(k, 2);
      @(negedge ref_clk);
      check(cfg_err_q, errs());
      for (k = 0; k < 4; k++)
        check(in_words_q[k*16 +: 16], exp_in(k));
      for (k = 0; k < 2; k++)
        if (cfg_out_mode[k*8 +: 8] !== 8'h00)
          check(dac_codes_q[k*12 +: 12], exp_out(k));
      if (analog_on && cfg_in_mode[31:24] !== 8'h00)
        check(conv_tmo_q, mute);
    end
  endtask
  //////////////////////////////////////////
  initial begin
    n = $urandom(32'h4f25d596);
    raw_tab = {RAWS[7], RAWS[6], RAWS[5], RAWS[4]};
    repeat (5) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(negedge ref_clk);
    check(in_words_q, {4{16'h7fff}});
    check(dac_codes_q, 24'h0);
    run(1'b0, 32'h80808080, 16'h1818, 1'b0, 1'b1);
    for (n = 0; n < 40; n++) begin
      for (i = 0; i < 4; i++) begin
        raw_tab[i*18 +: 18] = $urandom % 4 == 0 ? 18'($urandom)
          : RAWS[$urandom % 10];
        im[i*8 +: 8] = INS[$urandom % 5];
      end
      lag = 3'($urandom);
      @(posedge ref_clk);
      out_words <= {WDS[$urandom % 6], 16'($urandom)};
      // Output mode 00 exercises skipped channels
      run(1'b1, im, {INS[$urandom % 3], INS[$urandom % 3]},
        1'($urandom), n % 8 != 3);
    end
    mute = 1'b1;
    run(1'b1, 32'h18181818, 16'h1818, 1'b0, 1'b1);
    mute = 1'b0;
    // Fahrenheit edges on the thermometers, plus the 10k nominal point
    raw_tab = {RAWS[9], RAWS[8], RAWS[1], RAWS[0]};
    run(1'b1, 32'h80801849, 16'h1818, 1'b1, 1'b1);
    final_report;
  end
  initial begin
    repeat (80000) @(posedge ref_clk);
    err_total = err_total + 1;
    final_report;
  end
endmodule
bind avcm_top avcm_checker avcm_checker_i (.ref_clk(ref_clk),
  .sys_rst(sys_rst), .analog_on(analog_on), .out_words(out_words),
  .adc_done(adc_done), .adc_req_q(adc_req_q), .adc_chan_q(adc_chan_q),
  .in_words_q(in_words_q), .in_fresh_q(in_fresh_q),
  .dac_codes_q(dac_codes_q), .dac_load_q(dac_load_q),
  .dac_chan_q(dac_chan_q), .cfg_err_q(cfg_err_q),
  .cycle_done_q(cycle_done_q));
